// ### common/iccr_pkg.sv
// Purpose: shared constants for the i/o cell control and routing block
// Assumes: one hclk domain, AHB-Lite register access
// Notes:   offsets are byte addresses of aligned 32-bit words
package iccr_pkg;

    // peripheral control bus
    localparam int NUM_SLOTS = 12;
    localparam int DED_PINS  = 6;
    localparam int DED_CLKS  = 2;
    localparam int NUM_WIDE  = 4;
    localparam int NUM_OE    = 8;
    localparam int NUM_CE    = 6;

    // slot sharing of the bus
    localparam int SLOT_CE0   = 6;
    localparam int SLOT_BUS_TIMING_0  = 6;
    localparam int SLOT_OE6   = 7;
    localparam int SLOT_BUS_WIPE_0  = 8;
    localparam int SLOT_OE7   = 9;
    localparam int SLOT_BUS_WIPE_1  = 10;
    localparam int SLOT_BUS_TIMING_1  = 11;
    localparam int WIDE_SLOT [NUM_WIDE] = '{6, 7, 9, 11};

    // register offsets
    localparam logic [31:0] CTRL_OFS     = 32'h0000_0000;
    localparam logic [31:0] SLOT_SRC_OFS = 32'h0000_0010;
    localparam logic [31:0] PIN_STAT_OFS = 32'h0000_0040;
    localparam logic [31:0] BUS_STAT_OFS = 32'h0000_0044;
    localparam logic [31:0] CELL_CFG_OFS = 32'h0000_0080;

    // control register fields
    localparam int CTRL_W         = 5;
    localparam int CTRL_WIDE_LSB  = 0;
    localparam int CTRL_CHIP_OE   = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

    // slot source fields
    localparam int SRC_W        = 5;
    localparam int SRC_IDX_LSB  = 0;
    localparam int SRC_KIND_BIT = 4;
    localparam logic [SRC_W-1:0] SRC_RST = 5'h00;

    // cell configuration fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_REG_BIT  = 2;
    localparam int CFG_COL_BIT  = 3;
    localparam int CFG_OE_LSB   = 4;
    localparam int CFG_CE_LSB   = 8;
    localparam int CFG_CLK_LSB  = 11;
    localparam int CFG_CLR_LSB  = 13;
    localparam int CFG_ROW_LSB  = 16;
    localparam int CFG_COL_LSB  = 24;
    localparam int ROW_SW       = 6;
    localparam int COL_SW       = 5;
    localparam logic [3:0] OE_FROM_CELL = 4'h8;
    localparam logic [3:0] OE_ALWAYS    = 4'h9;
    localparam logic [2:0] CE_FROM_CELL = 3'h6;
    localparam logic [2:0] CE_ALWAYS    = 3'h7;
    localparam logic [31:0] CELL_CFG_RST = 32'h0000_0700;

    // column subset shift from one cell to the next
    localparam int COL_BASE_STEP = 1;

    typedef enum logic [1:0] {
        MODE_IN    = 2'h0,
        MODE_OUT   = 2'h1,
        MODE_BIDIR = 2'h2
    } iccr_mode_e;

endpackage

// ### tb/iccr_pin_model.sv
// Purpose: board side of the cell pins
// Assumes: board holds a fixed level on every pin the cell releases
// Notes:   no contention modelled; the board yields whenever a cell drives
`timescale 1ns/1ps
module iccr_pin_model #(
    parameter int N = 16
) (
    // cell side
    input  wire logic [N-1:0] pad_out,
    input  wire logic [N-1:0] pad_oe_n,
    // board level
    input  wire logic [N-1:0] board_lvl,
    // wire level back to the input buffers
    output logic      [N-1:0] pad_in
);
    assign pad_in = (pad_out & ~pad_oe_n) | (board_lvl & pad_oe_n);
endmodule

// ### tb/iccr_top_properties.sv
// Purpose: port-level checks of the i/o cell control and routing block
// Assumes: single hclk domain, one bus master, hready fed from hreadyout
// Notes:   the control word is shadowed from bus writes, since it is not on a port
`timescale 1ns/1ps
module iccr_top_properties
    import iccr_pkg::*;
#(
    parameter int NUM_CELLS = 16
) (
    // clock, reset and bus
    input wire logic                    hclk,
    input wire logic                    hresetn,
    input wire logic                    hsel,
    input wire logic [31:0]             haddr,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic [2:0]              hsize,
    input wire logic [31:0]             hwdata,
    input wire logic                    hready,
    input wire logic                    hreadyout,
    input wire logic                    hresp,
    input wire logic [31:0]             hrdata,
    // pins and routing
    input wire logic                    chip_oe_n,
    input wire logic [DED_PINS-1:0]     ded_in,
    input wire logic [2*NUM_CELLS-1:0]  row_drive,
    input wire logic [2*NUM_CELLS-1:0]  col_drive,
    input wire logic [NUM_CELLS-1:0]    pad_oe_n,
    input wire logic [NUM_WIDE-1:0]     wide_net
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic                   rd_go;
    logic                   wr_ctrl;
    logic [CTRL_W-1:0]      ctrl_sh;
    logic [NUM_CELLS-1:0]   pair_x;
    assign rd_go = hsel & htrans[1] & hready & !hwrite;
    for (genvar i = 0; i < NUM_CELLS; i++) begin : g_pair
        assign pair_x[i] = row_drive[2*i] ^ row_drive[2*i+1];
    end
    // write data comes a cycle after its address, so the address match is kept one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ctrl <= 1'b0;
            ctrl_sh <= CTRL_RST;
        end else begin
            wr_ctrl <= hsel & htrans[1] & hready & hwrite & (hsize == 3'h2) & (haddr[31:2] == CTRL_OFS[31:2]);
            if (wr_ctrl) begin
                ctrl_sh <= hwdata[CTRL_W-1:0];
            end
        end
    end
    property p_hresp_okay; hresp == 1'b0; endproperty
    a_hresp_okay: assert property (p_hresp_okay) else $error("bus response not okay");
    property p_read_wait; rd_go |=> !hreadyout ##1 hreadyout; endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    property p_read_ctrl; rd_go && haddr[31:2] == CTRL_OFS[31:2] |-> ##2 hrdata == 32'(ctrl_sh); endproperty
    a_read_ctrl: assert property (p_read_ctrl) else $error("control word readback wrong");
    property p_wide_pin; ((wide_net ^ ded_in[NUM_WIDE-1:0]) & ~ctrl_sh[NUM_WIDE-1:0]) == '0; endproperty
    a_wide_pin: assert property (p_wide_pin) else $error("global net lost its input pin");
    property p_chip_oe; ctrl_sh[CTRL_CHIP_OE] && !chip_oe_n |=> &pad_oe_n; endproperty
    a_chip_oe: assert property (p_chip_oe) else $error("pins not floated by chip enable");
    property p_row_pair; pair_x == '0; endproperty
    a_row_pair: assert property (p_row_pair) else $error("row channel pair differs");
    property p_col_row; col_drive == row_drive; endproperty
    a_col_row: assert property (p_col_row) else $error("column drive differs from row drive");
    property p_release; $rose(hresetn) |-> &pad_oe_n && hreadyout && hrdata == 32'h0; endproperty
    a_release: assert property (p_release) else $error("reset values wrong");
endmodule

// ### tb/iccr_top_tb.sv
// Purpose: directed bench of the i/o cell control and routing block
// Assumes: default sizes, 18 of 144 row and 16 of 24 column channels
// Notes:   bus waits are bounded, a stuck slave ends the run
`timescale 1ns/1ps
module iccr_top_tb;
    import iccr_pkg::*;
    logic           hclk, hresetn, hsel, hwrite, hreadyout, hresp, chip_reset_n, chip_oe_n;
    logic [31:0]    haddr, hwdata, hrdata, rd_val;
    logic [1:0]     htrans;
    logic [2:0]     hsize;
    logic [5:0]     ded_in;
    logic [1:0]     ded_clk;
    logic [47:0]    row_first_cell;
    logic [15:0]    lc_capture_en, lc_drive_en, pad_in, pad_out, pad_oe_n, chan_drive_en, board_lvl;
    logic [143:0]   row_chan;
    logic [23:0]    col_chan;
    logic [31:0]    row_drive, col_drive;
    logic [3:0]     wide_net;
    int             n_fail, compares;
    iccr_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .chip_reset_n, .chip_oe_n, .ded_in, .ded_clk, .row_first_cell,
        .lc_capture_en, .lc_drive_en, .row_chan, .col_chan, .row_drive, .col_drive, .chan_drive_en,
        .pad_in, .pad_out, .pad_oe_n, .wide_net);
    iccr_pin_model #(.N(16)) u_pins (.pad_out, .pad_oe_n, .board_lvl, .pad_in);
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // hready is judged at the falling edge, where it has settled for the coming rising edge
    task automatic wt();
        int k;
        k = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && k < 20) begin
            @(negedge hclk);
            k++;
        end
        if (k >= 20) begin
            n_fail++;
            tally_and_finish();
        end
        @(posedge hclk);
    endtask
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        rd_val = hrdata;
    endtask
    task automatic pulse();
        ded_clk[0] <= 1'b1;
        step(2);
        ded_clk[0] <= 1'b0;
        step(4);
    endtask
    task automatic t_regs();
        xfer(0, CTRL_OFS, 0);
        chk(rd_val, 32'h0);
        xfer(0, CELL_CFG_OFS, 0);
        chk(rd_val, CELL_CFG_RST);
        xfer(0, 32'h0000_0200, 0);
        chk(rd_val, 32'h0);
        xfer(1, CTRL_OFS, 32'h0000_001F);
        xfer(0, CTRL_OFS, 0);
        chk(rd_val, 32'h0000_001F);
        xfer(1, CTRL_OFS, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_wide();
        ded_in <= 6'h2A;
        step(2);
        chk(32'(wide_net), 32'hA);
        xfer(1, SLOT_SRC_OFS + 32'h18, 32'h0000_0005);
        xfer(1, SLOT_SRC_OFS + 32'h1C, 32'h0000_0012);
        row_first_cell <= 48'h0000_4000_0000;
        xfer(1, CTRL_OFS, 32'h3);
        step(2);
        chk(32'(wide_net), 32'hB);
        xfer(0, BUS_STAT_OFS, 0);
        chk(rd_val, 32'h0000_B0C0);
        row_first_cell <= 48'h0;
        ded_in <= 6'h2B;
        step(2);
        chk(32'(wide_net), 32'h9);
        ded_in <= 6'h2A;
        xfer(1, CTRL_OFS, 32'h0);
        $display("test global nets done");
    endtask
    task automatic t_oe();
        xfer(1, CELL_CFG_OFS, 32'h0000_0781);
        step(3);
        chk(32'(pad_oe_n[0]), 32'h1);
        lc_drive_en <= 16'h0001;
        step(3);
        chk(32'(pad_oe_n[0]), 32'h0);
        chip_oe_n <= 1'b0;
        step(3);
        chk(32'(pad_oe_n[0]), 32'h0);
        xfer(1, CTRL_OFS, 32'h10);
        step(2);
        chk(32'(pad_oe_n), 32'hFFFF);
        chip_oe_n <= 1'b1;
        step(3);
        chk(32'(pad_oe_n[0]), 32'h0);
        xfer(1, CTRL_OFS, 32'h0);
        $display("test output enable done");
    endtask
    task automatic t_route();
        int p;
        for (p = 16; p <= 18; p++) begin
            xfer(1, CELL_CFG_OFS + 32'h4, 32'h0000_0791 | (p << 16));
            row_chan <= (p < 18) ? (144'h1 << ((18 + p) % 144)) : '1;
            step(3);
            chk(32'(pad_out[1]), 32'(p < 18));
        end
        xfer(1, CELL_CFG_OFS + 32'h8, 32'h0F00_0799);
        xfer(1, CELL_CFG_OFS + 32'hC, 32'h0F00_0799);
        col_chan <= 24'h1 << 17;
        step(3);
        chk(32'(pad_out[3:2]), 32'h1);
        xfer(1, CELL_CFG_OFS + 32'h8, 32'h1000_0799);
        col_chan <= '1;
        step(3);
        chk(32'(pad_out[2]), 32'h0);
        $display("test routing done");
    endtask
    task automatic t_input();
        xfer(1, CELL_CFG_OFS, 32'h0000_0700);
        board_lvl <= 16'h0001;
        step(4);
        chk(32'(row_drive[1:0]), 32'h3);
        chk(32'(col_drive[1:0]), 32'h3);
        chk(32'(chan_drive_en[0]), 32'h1);
        xfer(0, PIN_STAT_OFS, 0);
        chk(rd_val & 32'h1, 32'h1);
        board_lvl <= 16'h0000;
        step(4);
        chk(32'(row_drive[1:0]), 32'h0);
        $display("test input done");
    endtask
    task automatic t_capture();
        xfer(1, CELL_CFG_OFS + 32'h10, 32'h0000_1604);
        board_lvl <= 16'h0010;
        step(4);
        pulse();
        chk(32'(row_drive[8]), 32'h0);
        lc_capture_en <= 16'h0010;
        pulse();
        chk(32'(row_drive[8]), 32'h1);
        board_lvl <= 16'h0000;
        step(4);
        chk(32'(row_drive[8]), 32'h1);
        chip_reset_n <= 1'b0;
        board_lvl <= 16'h0010;
        pulse();
        chk(32'(row_drive[8]), 32'h0);
        chip_reset_n <= 1'b1;
        step(4);
        chk(32'(row_drive[8]), 32'h0);
        pulse();
        chk(32'(row_drive[8]), 32'h1);
        xfer(1, SLOT_SRC_OFS + 32'h20, 32'h0000_0001);
        xfer(1, CELL_CFG_OFS + 32'h10, 32'h0000_3604);
        pulse();
        chk(32'(row_drive[8]), 32'h0);
        $display("test capture done");
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize, ded_in, ded_clk} = '0;
        {row_first_cell, lc_capture_en, lc_drive_en, row_chan, col_chan, board_lvl} = '0;
        chip_reset_n = 1'b1;
        chip_oe_n = 1'b1;
        n_fail = 0;
        compares = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_wide();
        t_oe();
        t_route();
        t_input();
        t_capture();
        tally_and_finish();
    end
endmodule
bind iccr_top iccr_top_properties #(.NUM_CELLS(NUM_CELLS)) u_props (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .chip_oe_n, .ded_in,
    .row_drive, .col_drive, .pad_oe_n, .wide_net);

// ### verilog/iccr_cell.sv
// Purpose: one i/o cell with pin buffer controls and one register
// Assumes: timing strobe is a level sampled on hclk
// Notes:   a rising strobe edge is seen one hclk after it arrives
`timescale 1ns/1ps
module iccr_cell
    import iccr_pkg::*;
(
    // clock and resets
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       chip_reset_n,
    // configuration
    input  iccr_pkg::iccr_mode_e mode,
    input  wire logic       use_reg,
    input  wire logic       force_hiz,
    // selected controls
    input  wire logic       tick,
    input  wire logic       cap_en,
    input  wire logic       wipe,
    input  wire logic       drive_en,
    // data
    input  wire logic       out_data,
    input  wire logic       pad_in,
    output logic            pad_out,
    output logic            pad_oe_n,
    output logic            pin_val
);
    logic tick_q;
    logic io_reg;
    logic in_q;
    logic is_out;
    logic rise;

    assign is_out = (mode == MODE_OUT) || (mode == MODE_BIDIR);
    assign rise   = tick & ~tick_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick;
        end
    end

    // chip reset beats the wipe, the wipe beats a capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_reg <= 1'b0;
        end else if (!chip_reset_n) begin
            io_reg <= 1'b0;
        end else if (wipe) begin
            io_reg <= 1'b0;
        end else if (rise && cap_en) begin
            io_reg <= is_out ? out_data : pad_in;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_q <= 1'b0;
        end else begin
            in_q <= pad_in;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_out  <= 1'b0;
            pad_oe_n <= 1'b1;
        end else begin
            pad_out  <= use_reg ? io_reg : out_data;
            pad_oe_n <= ~(is_out & drive_en) | force_hiz;
        end
    end

    // in bidir mode the register serves the output side only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_val <= 1'b0;
        end else begin
            pin_val <= (use_reg && mode == MODE_IN) ? io_reg : in_q;
        end
    end
endmodule

// ### verilog/iccr_chan_mux.sv
// Purpose: picks one channel out of a window of routing channels
// Assumes: window starts at BASE and wraps around the channel count
// Notes:   a pick beyond the window yields zero
`timescale 1ns/1ps
module iccr_chan_mux #(
    parameter int CH   = 144,
    parameter int SEL  = 18,
    parameter int BASE = 0,
    parameter int SW   = 6
) (
    // channels
    input  wire logic [CH-1:0] chan,
    // selection
    input  wire logic [SW-1:0] pick,
    output logic               picked
);
    always_comb begin
        picked = 1'b0;
        for (int k = 0; k < SEL; k++) begin
            if (pick == SW'(k)) begin
                picked = chan[(BASE + k) % CH];
            end
        end
    end
endmodule

// ### verilog/iccr_top.sv
// Purpose: i/o cell control bus, routing muxes and register file
// Assumes: AHB-Lite single word transfers, one hclk domain
// Notes:   reads take one wait state, writes none
//
// What this block does
// - cells pick clock, clear, enables from bus
// - control bus has twelve lines
// - fixed sharing of slots among control roles
// - logic cell may drive enables directly
// - two dedicated clock pins also clock cells
// - lines driven by pin or row cell
// - chip reset clears every cell register first
// - chip output enable low floats all pins
// - four bus lines may feed global nets
// - driven global net drops its input pin
// - input cell drives two row channels
// - output data from row channel mux
// - row mux window size per device
// - two column channels in, column mux out
// - column mux window size per device
// - column window differs per cell
// - cell holds buffer and one register
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module iccr_top
    import iccr_pkg::*;
#(
    parameter int NUM_CELLS = 16,
    parameter int CLUSTERS  = 4,
    parameter int ROW_CH    = 144,
    parameter int ROW_SEL   = 18,
    parameter int COL_CH    = 24,
    parameter int COL_SEL   = 16
) (
    // clock and reset
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    // AHB-Lite slave
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic [31:0]                        hrdata,
    // chip-wide pins
    input  wire logic                          chip_reset_n,
    input  wire logic                          chip_oe_n,
    // dedicated inputs and clocks
    input  wire logic [iccr_pkg::DED_PINS-1:0] ded_in,
    input  wire logic [iccr_pkg::DED_CLKS-1:0] ded_clk,
    // first logic cells of the assigned rows
    input  wire logic [iccr_pkg::NUM_SLOTS*CLUSTERS-1:0] row_first_cell,
    // direct enables from logic cells
    input  wire logic [NUM_CELLS-1:0]          lc_capture_en,
    input  wire logic [NUM_CELLS-1:0]          lc_drive_en,
    // routing channels
    input  wire logic [ROW_CH-1:0]             row_chan,
    input  wire logic [COL_CH-1:0]             col_chan,
    output logic [2*NUM_CELLS-1:0]             row_drive,
    output logic [2*NUM_CELLS-1:0]             col_drive,
    output logic [NUM_CELLS-1:0]               chan_drive_en,
    // pins
    input  wire logic [NUM_CELLS-1:0]          pad_in,
    output logic [NUM_CELLS-1:0]               pad_out,
    output logic [NUM_CELLS-1:0]               pad_oe_n,
    // global nets
    output logic [iccr_pkg::NUM_WIDE-1:0]      wide_net
);
    logic [CTRL_W-1:0]    ctrl;
    logic [SRC_W-1:0]     slot_src [NUM_SLOTS];
    logic [31:0]          cell_cfg [NUM_CELLS];
    logic [NUM_SLOTS-1:0] slot_val;
    logic [NUM_OE-1:0]    bus_oe;
    logic [NUM_CE-1:0]    bus_ce;
    logic [1:0]           bus_tick;
    logic [1:0]           bus_wipe;
    logic [NUM_CELLS-1:0] pin_vals;
    logic                 force_hiz;

    logic        wr_pend;
    logic        rd_pend;
    logic [31:0] bus_addr;
    logic [31:0] rd_mux;
    logic        accept;

    // AHB-Lite slave
    assign accept    = hsel & htrans[1] & hready;
    assign hreadyout = ~rd_pend;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend  <= 1'b0;
            rd_pend  <= 1'b0;
            bus_addr <= 32'h0000_0000;
        end else begin
            wr_pend <= accept & hwrite & (hsize == 3'h2);
            rd_pend <= accept & ~hwrite;
            if (accept) begin
                bus_addr <= {haddr[31:2], 2'b00};
            end
        end
    end

    // the wait state lets a write just before a read land first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend) begin
            hrdata <= rd_mux;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (bus_addr == CTRL_OFS) begin
            rd_mux = 32'(ctrl);
        end
        if (bus_addr == PIN_STAT_OFS) begin
            rd_mux = 32'(pin_vals);
        end
        if (bus_addr == BUS_STAT_OFS) begin
            rd_mux = {16'h0000, wide_net, slot_val};
        end
        for (int s = 0; s < NUM_SLOTS; s++) begin
            if (bus_addr == SLOT_SRC_OFS + 32'(4 * s)) begin
                rd_mux = 32'(slot_src[s]);
            end
        end
        for (int i = 0; i < NUM_CELLS; i++) begin
            if (bus_addr == CELL_CFG_OFS + 32'(4 * i)) begin
                rd_mux = cell_cfg[i];
            end
        end
    end

    // registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= CTRL_RST;
        end else if (wr_pend && bus_addr == CTRL_OFS) begin
            ctrl <= hwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int s = 0; s < NUM_SLOTS; s++) begin
                slot_src[s] <= SRC_RST;
            end
        end else begin
            for (int s = 0; s < NUM_SLOTS; s++) begin
                if (wr_pend && bus_addr == SLOT_SRC_OFS + 32'(4 * s)) begin
                    slot_src[s] <= hwdata[SRC_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_CELLS; i++) begin
                cell_cfg[i] <= CELL_CFG_RST;
            end
        end else begin
            for (int i = 0; i < NUM_CELLS; i++) begin
                if (wr_pend && bus_addr == CELL_CFG_OFS + 32'(4 * i)) begin
                    cell_cfg[i] <= hwdata;
                end
            end
        end
    end

    // peripheral control bus
    // an out-of-range source index reads as low rather than aliasing
    always_comb begin
        for (int s = 0; s < NUM_SLOTS; s++) begin
            slot_val[s] = 1'b0;
            if (slot_src[s][SRC_KIND_BIT]) begin
                for (int c = 0; c < CLUSTERS; c++) begin
                    if (slot_src[s][SRC_IDX_LSB +: 4] == 4'(c)) begin
                        slot_val[s] = row_first_cell[s * CLUSTERS + c];
                    end
                end
            end else begin
                for (int p = 0; p < DED_PINS; p++) begin
                    if (slot_src[s][SRC_IDX_LSB +: 4] == 4'(p)) begin
                        slot_val[s] = ded_in[p];
                    end
                end
            end
        end
    end

    // twelve lines shared among the control roles
    assign bus_oe      = {slot_val[SLOT_OE7], slot_val[SLOT_OE6], slot_val[5:0]};
    assign bus_ce      = slot_val[SLOT_CE0 +: NUM_CE];
    assign bus_tick[0] = slot_val[SLOT_BUS_TIMING_0];
    assign bus_tick[1] = slot_val[SLOT_BUS_TIMING_1];
    assign bus_wipe[0] = slot_val[SLOT_BUS_WIPE_0];
    assign bus_wipe[1] = slot_val[SLOT_BUS_WIPE_1];

    assign force_hiz = ctrl[CTRL_CHIP_OE] & ~chip_oe_n;

    // a bus-fed global net no longer listens to its own pin
    always_comb begin
        for (int k = 0; k < NUM_WIDE; k++) begin
            wide_net[k] = ctrl[CTRL_WIDE_LSB + k] ? slot_val[WIDE_SLOT[k]] : ded_in[k];
        end
    end

    // i/o cells
    for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
        logic [31:0] cfg;
        logic [3:0]  oe_src;
        logic [2:0]  ce_src;
        logic [1:0]  clk_src;
        logic [1:0]  clr_src;
        logic        drive_en;
        logic        cap_en;
        logic        tick;
        logic        wipe;
        logic        row_pick;
        logic        col_pick;
        logic        out_data;

        assign cfg     = cell_cfg[i];
        assign oe_src  = cfg[CFG_OE_LSB +: 4];
        assign ce_src  = cfg[CFG_CE_LSB +: 3];
        assign clk_src = cfg[CFG_CLK_LSB +: 2];
        assign clr_src = cfg[CFG_CLR_LSB +: 2];

        always_comb begin
            if (oe_src < OE_FROM_CELL) begin
                drive_en = bus_oe[oe_src[2:0]];
            end else if (oe_src == OE_FROM_CELL) begin
                drive_en = lc_drive_en[i];
            end else begin
                drive_en = (oe_src == OE_ALWAYS);
            end
        end

        always_comb begin
            if (ce_src < CE_FROM_CELL) begin
                cap_en = bus_ce[ce_src];
            end else if (ce_src == CE_FROM_CELL) begin
                cap_en = lc_capture_en[i];
            end else begin
                cap_en = 1'b1;
            end
        end

        always_comb begin
            case (clk_src)
                2'h0:    tick = bus_tick[0];
                2'h1:    tick = bus_tick[1];
                2'h2:    tick = ded_clk[0];
                default: tick = ded_clk[1];
            endcase
        end

        always_comb begin
            case (clr_src)
                2'h1:    wipe = bus_wipe[0];
                2'h2:    wipe = bus_wipe[1];
                default: wipe = 1'b0;
            endcase
        end

        // row windows repeat every few cells, as for cells on opposite sides
        iccr_chan_mux #(
            .CH   (ROW_CH),
            .SEL  (ROW_SEL),
            .BASE ((i * ROW_SEL) % ROW_CH),
            .SW   (ROW_SW)
        ) u_row_mux (
            .chan   (row_chan),
            .pick   (cfg[CFG_ROW_LSB +: ROW_SW]),
            .picked (row_pick)
        );

        iccr_chan_mux #(
            .CH   (COL_CH),
            .SEL  (COL_SEL),
            .BASE ((i * COL_BASE_STEP) % COL_CH),
            .SW   (COL_SW)
        ) u_col_mux (
            .chan   (col_chan),
            .pick   (cfg[CFG_COL_LSB +: COL_SW]),
            .picked (col_pick)
        );

        assign out_data = cfg[CFG_COL_BIT] ? col_pick : row_pick;

        iccr_cell u_cell (
            .hclk         (hclk),
            .hresetn      (hresetn),
            .chip_reset_n (chip_reset_n),
            .mode         (iccr_mode_e'(cfg[CFG_MODE_LSB +: 2])),
            .use_reg      (cfg[CFG_REG_BIT]),
            .force_hiz    (force_hiz),
            .tick         (tick),
            .cap_en       (cap_en),
            .wipe         (wipe),
            .drive_en     (drive_en),
            .out_data     (out_data),
            .pad_in       (pad_in[i]),
            .pad_out      (pad_out[i]),
            .pad_oe_n     (pad_oe_n[i]),
            .pin_val      (pin_vals[i])
        );

        assign row_drive[2*i +: 2] = {2{pin_vals[i]}};
        assign col_drive[2*i +: 2] = {2{pin_vals[i]}};
        assign chan_drive_en[i]    = (cfg[CFG_MODE_LSB +: 2] != MODE_OUT);
    end
endmodule
